// ===== pbsp_pkg.sv
/*
  shared types and constants of the pipelined burst memory port.
  assumes one 25 MHz clock and a controller on that same clock.
*/
package pbsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and lane layout
  localparam int ADDR_W_DFLT = 18;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int SYNC_LEN = 3;

  ////////////////////////////////////////////////////////////////////////////
  // burst counter and byte select codes
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;
  localparam logic [1:0] NO_BYTES_N = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // sleep entry and exit, in clock cycles
  localparam logic [1:0] SLEEP_CYC = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [1:0] RST_PIPE_VAL = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // one word on the shared lines: two data bytes and their parity bits
  typedef struct packed {
    logic [LANES-1:0] parity;
    logic [LANES*BYTE_W-1:0] data;
  } pbsp_word_t;

  // synchronous command group sampled at each rising edge
  typedef struct packed {
    logic clock_qualify_n;
    logic chip_select_one_n;
    logic chip_select_two;
    logic chip_select_three_n;
    logic advance_load;
    logic write_enable_n;
    logic [LANES-1:0] byte_select_n;
  } pbsp_ctl_t;

endpackage : pbsp_pkg

// ===== pbsp_wbuf.sv
/*
  small fifo with valid and ready on both sides.
  assumes an asynchronous, synchronously released active low reset.
*/
module pbsp_wbuf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [CW-1:0] count;
  } pbsp_wbuf_state_t;

  pbsp_wbuf_state_t st;
  pbsp_wbuf_state_t next_st;
  logic push;
  logic pop;

  // pointer step with wrap at the depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  // handshake terms from the count
  assign in_ready = (st.count != CW'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = st.slot[st.head];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next slot contents, pointers and fill count
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.tail] = in_data;
      next_st.tail = bump(st.tail);
    end
    if (pop) begin
      next_st.head = bump(st.head);
    end
    if (push && !pop) begin
      next_st.count = CW'(st.count + 1'b1);
    end else if (pop && !push) begin
      next_st.count = CW'(st.count - 1'b1);
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : pbsp_wbuf

// ===== pbsp_core.sv
/*
  pipelined burst static memory port: command pipeline, burst counter,
  byte writes through a two-entry buffer, output drive and sleep.
  assumes the controller runs on the same clock; output enable and sleep
  are asynchronous pins, the burst order pin is a static strap.
*/
//
// Behaviour
// - clock qualify high: edge ignored, pipeline, burst and output word held.
// - qualified load edge with all selects active captures the address.
// - read command: word driven after the following edge if enabled.
// - after the first read cycle output enable gates the drivers.
// - a new command is accepted the cycle right after a read.
// - deselect at a load edge releases outputs after the next edge.
// - burst counter steps the two low address bits, wraps in four.
// - strap low gives linear order, high or open gives interleaved.
// - advance edge steps the counter, ignores selects and write enable.
// - write enable captured at load, direction kept for the burst.
// - write command captures address and latches byte selects.
// - edge after a write command forces drivers off.
// - write data taken two edges after the command, completes write.
// - only bytes with active byte select are changed.
// - interleaved beats are start xor 01, 10, 11.
// - linear beats add one modulo four to the low bits.
// - sleep entry and exit each take two cycles, contents kept.
// - accesses in the command pipeline at sleep entry are dropped.
// - write with no byte select writes nothing, drivers stay off.
// - after power-up the port is deselected, drivers off.
// - drivers stay off the first clock after a deselected state.
module pbsp_core
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DFLT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // synchronous command and address
  input wire pbsp_ctl_t ctl,
  input wire logic [ADDR_W-1:0] address,
  // asynchronous controls and strap
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  // shared data and parity lines
  input wire pbsp_word_t dq_in,
  output pbsp_word_t dq_out,
  output logic dq_oe,
  // status
  output logic sleeping
);

  ////////////////////////////////////////////////////////////////////////////
  // types

  // one beat moving down the command pipeline
  typedef struct packed {
    logic vld;
    logic wr;
    logic [LANES-1:0] byte_n;
    logic [ADDR_W-1:0] addr;
  } pbsp_beat_t;

  // one pending write held in the buffer
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be;
    pbsp_word_t word;
  } pbsp_wr_t;

  typedef struct packed {
    logic [SYNC_LEN-1:0] oe_sync;
    logic [SYNC_LEN-1:0] zz_sync;
    logic oe_on;
    logic zz_on;
    logic strap_done;
    logic interleave;
    logic [1:0] zz_cnt;
    logic asleep;
    logic [ADDR_W-1:0] addr;
    logic [1:0] start;
    logic [1:0] beat;
    logic burst_wr;
    logic active;
    pbsp_beat_t s1;
    pbsp_beat_t s2;
    logic rd_vld;
    pbsp_word_t q;
    logic drive;
  } pbsp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0] rst_pipe;
  logic rst_core_n;
  pbsp_state_t st;
  pbsp_state_t next_st;
  logic q_edge;
  logic sel;
  pbsp_word_t rd_word;
  pbsp_wr_t buf_in;
  pbsp_wr_t buf_head;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  pbsp_word_t mem [2**ADDR_W];

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // low address bits of a burst beat
  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] beat,
    input logic il
  );
    burst_low = il ? (start ^ beat) : 2'(start + beat);
  endfunction : burst_low

  // overlay enabled lanes of a new word on an old one
  function automatic pbsp_word_t merge(
    input pbsp_word_t old,
    input pbsp_word_t nw,
    input logic [LANES-1:0] be
  );
    merge = old;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        merge.data[i*BYTE_W +: BYTE_W] = nw.data[i*BYTE_W +: BYTE_W];
        merge.parity[i] = nw.parity[i];
      end
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  // two-stage release of the external reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= RST_PIPE_VAL;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_core_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // memory array and write buffer

  // stall drain while asleep; stalled buffer stalls the pipeline
  assign buf_out_ready = !st.asleep;

  pbsp_wbuf #(
    .WIDTH($bits(pbsp_wr_t)),
    .DEPTH(2)
  ) u_wbuf (
    .clock(clock),
    .rst_n(rst_core_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_head)
  );

  // array update from the buffer head, contents kept through sleep
  always_ff @(posedge clock) begin
    if (buf_out_valid && buf_out_ready) begin
      mem[buf_head.addr] <= merge(mem[buf_head.addr], buf_head.word,
                                  buf_head.be);
    end
  end

  // read lookup with forwarding of writes not yet in the array
  always_comb begin
    rd_word = mem[st.s1.addr];
    if (buf_out_valid && buf_head.addr == st.s1.addr) begin
      rd_word = merge(rd_word, buf_head.word, buf_head.be);
    end
    if (buf_in_valid && st.s2.addr == st.s1.addr) begin
      rd_word = merge(rd_word, dq_in, ~st.s2.byte_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge qualification and write data capture

  // masked edge, also held on a full buffer
  assign q_edge = !ctl.clock_qualify_n && !st.asleep
                  && (buf_in_ready || !st.s2.vld);
  assign sel = !ctl.chip_select_one_n && ctl.chip_select_two
               && !ctl.chip_select_three_n;

  // data taken on the second edge after the command
  assign buf_in_valid = q_edge && st.s2.vld && (st.s2.byte_n != NO_BYTES_N);
  assign buf_in = '{addr: st.s2.addr, be: ~st.s2.byte_n, word: dq_in};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // pin synchronisers: change taken once stages two and three agree
    next_st.oe_sync = {st.oe_sync[SYNC_LEN-2:0], output_enable_n};
    next_st.zz_sync = {st.zz_sync[SYNC_LEN-2:0], sleep_request};
    if (st.oe_sync[2] == st.oe_sync[1]) begin
      next_st.oe_on = !st.oe_sync[2];
    end
    if (st.zz_sync[2] == st.zz_sync[1]) begin
      next_st.zz_on = st.zz_sync[2];
    end
    // strap taken once after reset release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.interleave = burst_order;
    end
    // two cycles to enter or leave sleep
    if (st.zz_on != st.asleep) begin
      if (st.zz_cnt == 2'(SLEEP_CYC - 2'h1)) begin
        next_st.asleep = st.zz_on;
        next_st.zz_cnt = 2'h0;
      end else begin
        next_st.zz_cnt = 2'(st.zz_cnt + 2'h1);
      end
    end else begin
      next_st.zz_cnt = 2'h0;
    end
    if (q_edge) begin
      // write beat moves to the data stage
      next_st.s2 = st.s1.wr ? st.s1 : '0;
      // read word enters the output register
      // a write beat clears the read flag
      next_st.rd_vld = st.s1.vld && !st.s1.wr;
      if (st.s1.vld && !st.s1.wr) begin
        next_st.q = rd_word;
      end
      // slot free for the next command
      next_st.s1 = '0;
      if (!ctl.advance_load) begin
        // deselect leaves the next beat empty
        next_st.active = sel;
        if (sel) begin
          next_st.addr = address;
          next_st.start = address[1:0];
          next_st.beat = BEAT_FIRST;
          next_st.burst_wr = !ctl.write_enable_n;
          next_st.s1.vld = 1'b1;
          next_st.s1.wr = !ctl.write_enable_n;
          next_st.s1.byte_n = ctl.byte_select_n;
          next_st.s1.addr = address;
        end
      end else if (st.active) begin
        next_st.beat = 2'(st.beat + BEAT_STEP);
        next_st.s1.vld = 1'b1;
        next_st.s1.wr = st.burst_wr;
        next_st.s1.byte_n = ctl.byte_select_n;
        next_st.s1.addr = {st.addr[ADDR_W-1:2],
                           burst_low(st.start, 2'(st.beat + BEAT_STEP),
                                     st.interleave)};
      end
    end
    if (st.asleep) begin
      next_st.s1 = '0;
      next_st.s2 = '0;
      next_st.rd_vld = 1'b0;
      next_st.active = 1'b0;
    end
    // no drive until a read reaches the output
    next_st.drive = next_st.rd_vld && st.oe_on;
  end

  // reset comes up deselected, drivers off
  always_ff @(posedge clock or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // registered pin outputs
  assign dq_out = st.q;
  assign dq_oe = st.drive;
  assign sleeping = st.asleep;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_core_n);

  AST_STALL_HOLD: assert property (
    ctl.clock_qualify_n |=>
      $stable(st.addr) && $stable(st.beat) && $stable(st.q)
  ) else $error("state changed on a masked edge");

  AST_LOAD_ADDR: assert property (
    q_edge && !ctl.advance_load && sel |=>
      st.addr == $past(address) && st.beat == BEAT_FIRST
  ) else $error("address not captured at load");

  AST_READ_DATA: assert property (
    q_edge && st.s1.vld && !st.s1.wr |=>
      st.rd_vld && dq_oe == $past(st.oe_on)
  ) else $error("read word not presented");

  // disabled output enable turns drivers off
  AST_OE_GATE: assert property (
    !st.oe_on |=> !dq_oe
  ) else $error("driving with output enable off");

  // command right after a read accepted
  AST_BACK_TO_BACK: assert property (
    q_edge && st.s1.vld && !st.s1.wr && !ctl.advance_load && sel |=>
      st.s1.vld && st.rd_vld
  ) else $error("command after read lost");

  // deselect releases after the next edge
  AST_DESELECT: assert property (
    q_edge && !ctl.advance_load && !sel ##1 q_edge |=>
      !st.rd_vld && !dq_oe
  ) else $error("outputs not released after deselect");

  // advance steps counter and keeps direction
  AST_BURST_STEP: assert property (
    q_edge && ctl.advance_load && st.active |=>
      st.beat == 2'($past(st.beat) + BEAT_STEP)
      && st.s1.vld && st.s1.wr == $past(st.burst_wr)
  ) else $error("burst counter did not advance");

  AST_INTERLEAVE: assert property (
    st.s1.vld && st.interleave |->
      st.s1.addr[1:0] == (st.start ^ st.beat)
  ) else $error("interleaved order wrong");

  AST_LINEAR: assert property (
    st.s1.vld && !st.interleave |->
      st.s1.addr[1:0] == 2'(st.start + st.beat)
  ) else $error("linear order wrong");

  // drivers off after a write command
  AST_WRITE_OFF: assert property (
    q_edge && st.s1.vld && st.s1.wr |=> !dq_oe
  ) else $error("driving during write data");

  // write beat reaches the data stage
  AST_WRITE_STAGE: assert property (
    q_edge && st.s1.vld && st.s1.wr |=>
      st.s2.vld && st.s2.addr == $past(st.s1.addr)
  ) else $error("write beat lost before data edge");

  AST_ABORT: assert property (
    st.s2.vld && st.s2.byte_n == NO_BYTES_N |-> !buf_in_valid && !dq_oe
  ) else $error("write with no byte select stored");

  AST_SLEEP_ENTER: assert property (
    !st.asleep && st.zz_on && st.zz_cnt == 2'h0 ##1 st.zz_on |=>
      st.asleep
  ) else $error("sleep not entered in two cycles");

  AST_SLEEP_FLUSH: assert property (
    st.asleep ##1 st.asleep |-> !st.rd_vld && !st.s1.vld && !dq_oe
  ) else $error("access survived sleep entry");

  AST_POWER_UP: assert property (
    !st.strap_done |-> !dq_oe
  ) else $error("driving at power-up");

endmodule : pbsp_core

// ===== pbsp_ctrl_model.sv
/*
  controller model for the pipelined burst memory port: it supplies write
  data two qualified edges after each posted write beat and resolves the
  shared data lines.
  assumes the bench posts a beat in the half cycle before its command edge.
*/
module pbsp_ctrl_model
  import pbsp_pkg::*;
(
  // clock
  input wire logic clock,
  // command lines, watched for qualified edges
  input wire pbsp_ctl_t ctl,
  // device drivers
  input wire pbsp_word_t dq_out,
  input wire logic dq_oe,
  // resolved lines seen by the device
  output pbsp_word_t dq_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    int due;
    pbsp_word_t word;
  } pbsp_beat_t;

  pbsp_beat_t pend_q[$];
  int qcount = 0;
  logic drive = 1'b0;
  pbsp_word_t drive_word = '0;
  pbsp_word_t float_word = 18'h2a5a5;

  ////////////////////////////////////////////////////////////////////////////
  // post: queue one write beat for the coming command edge
  task automatic post(input pbsp_word_t w);
    pbsp_beat_t b;
    b.due = qcount + 3;
    b.word = w;
    pend_q.push_back(b);
  endtask : post

  // count qualified edges and release the lines at each of them
  always @(posedge clock) begin
    if (ctl.clock_qualify_n === 1'b0) begin
      qcount <= qcount + 1;
      drive <= 1'b0;
    end
  end

  always @(negedge clock) begin
    while (pend_q.size() > 0 && pend_q[0].due <= qcount) begin
      void'(pend_q.pop_front());
    end
    drive = (pend_q.size() > 0) && (pend_q[0].due == qcount + 1);
    if (drive) begin
      drive_word = pend_q[0].word;
    end
    float_word = ~float_word; // undriven lines keep changing
  end

  // shared line resolution
  assign dq_wire = drive ? drive_word : (dq_oe ? dq_out : float_word);

endmodule : pbsp_ctrl_model

// ===== tb_pipelined_burst_sram_port.sv
/*
  self-checking bench of the burst memory port: a queue-free word model
  predicts every output word and driver state, per qualified edge.
  assumes the controller model and the core share one 25 MHz clock.
*/
`define CHK(nm, ex, got) begin check_count++; \
  if ((got) !== (ex)) begin \
    $display("Error %s expected %h seen %h", nm, ex, got); \
    miscompares++; end end

module tb_pipelined_burst_sram_port
  import pbsp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = 4;
  localparam pbsp_ctl_t DSEL = 8'h64;
  localparam pbsp_ctl_t RD = 8'h24;
  localparam pbsp_ctl_t WR = 8'h20;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  pbsp_ctl_t ctl = DSEL;
  logic [AW-1:0] address = '0;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_order = 1'b1;
  pbsp_word_t dq_in;
  pbsp_word_t dq_out;
  logic dq_oe;
  logic sleeping;
  int seed = 2764;
  int miscompares = 0;
  int check_count = 0;
  // word model and pipeline expectation
  pbsp_word_t mem [16];
  logic [AW-1:0] base = '0;
  int beat = 0;
  logic active = 1'b0;
  logic dir = 1'b1;
  logic oe_on = 1'b1;
  logic asleep = 1'b0;
  logic cur_oe = 1'b0;
  logic pend_oe = 1'b0;
  pbsp_word_t cur_val = '0;
  pbsp_word_t pend_val = '0;

  always #20 clock = ~clock;

  pbsp_core #(.ADDR_W(AW)) i_pbsp_core (
    .clock(clock), .rst_n(rst_n), .ctl(ctl), .address(address),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order(burst_order), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .sleeping(sleeping));

  pbsp_ctrl_model i_pbsp_ctrl_model (
    .clock(clock), .ctl(ctl), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_wire(dq_in));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd

  function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] b,
                                              input int n);
    logic [1:0] lo;
    lo = burst_order ? (b[1:0] ^ n[1:0]) : (b[1:0] + n[1:0]);
    return {b[AW-1:2], lo};
  endfunction : beat_addr

  // one command: check last edge's outputs, drive, predict
  task automatic step(input pbsp_ctl_t c, input logic [AW-1:0] a,
                      input pbsp_word_t w);
    logic go;
    logic nx_oe;
    logic [AW-1:0] at;
    pbsp_word_t nx_val;
    @(negedge clock);
    `CHK("dq_oe", cur_oe, dq_oe)
    if (cur_oe === 1'b1) `CHK("dq_out", cur_val, dq_out)
    ctl = c;
    address = a;
    go = (c.clock_qualify_n == 1'b0) && !asleep;
    nx_oe = 1'b0;
    nx_val = '0;
    if (go && !c.advance_load) begin
      active = !c.chip_select_one_n && c.chip_select_two &&
               !c.chip_select_three_n;
      base = a;
      beat = 0;
      dir = c.write_enable_n;
    end else if (go && active) begin
      beat++;
    end
    at = beat_addr(base, beat);
    if (go && active && dir) begin
      nx_oe = oe_on;
      nx_val = mem[at];
    end else if (go && active) begin
      for (int i = 0; i < LANES; i++) begin
        if (!c.byte_select_n[i]) begin
          mem[at].data[i*BYTE_W +: BYTE_W] = w.data[i*BYTE_W +: BYTE_W];
          mem[at].parity[i] = w.parity[i];
        end
      end
      i_pbsp_ctrl_model.post(w);
    end
    @(posedge clock);
    if (go) begin
      cur_oe = pend_oe;
      cur_val = pend_val;
      pend_oe = nx_oe;
      pend_val = nx_val;
    end
  endtask : step

  task automatic rd(input logic [AW-1:0] a);
    step(RD, a, '0);
  endtask : rd

  task automatic wr(input logic [AW-1:0] a, input logic [1:0] b);
    pbsp_ctl_t c;
    logic [31:0] r;
    c = WR;
    c.byte_select_n = b;
    r = rnd();
    step(c, a, r[17:0]);
  endtask : wr

  task automatic adv(input logic [1:0] b);
    logic [31:0] r;
    r = rnd();
    step({1'b0, r[2:0], 1'b1, r[3], b}, r[7:4], r[31:14]);
  endtask : adv

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // one full pass with the strap at a given level
  task automatic run(input logic order);
    logic [31:0] r;
    int n;
    burst_order <= order;
    rst_n <= 1'b0;
    repeat (8) @(negedge clock);
    `CHK("dq_oe reset", 1'b0, dq_oe)
    `CHK("sleeping reset", 1'b0, sleeping)
    rst_n = 1'b1;
    {cur_oe, pend_oe, active, asleep, oe_on} = 5'h01;
    repeat (6) step(DSEL, '0, '0);
    for (int g = 0; g < 4; g++) begin
      wr(4 * g, 2'h0);
      repeat (3) adv(2'h0);
    end
    // every start value, write a burst, then read the next group past the wrap
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      wr(4 * s + s, r[1:0]);
      repeat (3) adv(r[3:2] ^ r[5:4]);
      rd(4 * ((s + 1) % 4) + s);
      repeat (4) adv(2'h0);
    end
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      case (r[6:4])
        3'h0, 3'h1, 3'h7: rd(r[3:0]);
        3'h2: wr(r[3:0], r[9:8]);
        3'h3, 3'h4: adv(r[9:8]);
        3'h5: step({1'b0, r[12:11], ~r[12] & ~r[11], 1'b0, r[13],
                    r[15:14]}, r[3:0], '0);
        default: step({1'b1, r[16:10]}, r[3:0], r[31:14]);
      endcase
    end
    // reads with output enable high stay off the lines
    repeat (2) step(DSEL, '0, '0);
    output_enable_n <= 1'b1;
    repeat (6) step(DSEL, '0, '0);
    oe_on = 1'b0;
    rd(4'h1);
    adv(2'h0);
    output_enable_n <= 1'b0;
    repeat (6) step(DSEL, '0, '0);
    oe_on = 1'b1;
    sleep_request <= 1'b1;
    n = 0;
    while (sleeping !== 1'b1 && n < 12) begin
      step(DSEL, '0, '0);
      n++;
      #1;
    end
    `CHK("sleep entry", SYNC_LEN + 1 + SLEEP_CYC, n)
    asleep = 1'b1;
    wr(4'h5, 2'h0); // ignored while asleep
    rd(4'h5);
    sleep_request <= 1'b0;
    n = 0;
    while (sleeping !== 1'b0 && n < 12) begin
      step(DSEL, '0, '0);
      n++;
      #1;
    end
    `CHK("sleep exit", SYNC_LEN + 1 + SLEEP_CYC, n)
    asleep = 1'b0;
    repeat (3) step(DSEL, '0, '0);
    rd(4'h4);
    repeat (3) adv(2'h0);
    repeat (3) step(DSEL, '0, '0);
  endtask : run

  // watchdog on the whole run
  initial begin
    #(40 * 3000);
    miscompares++;
    test_done();
  end

  // main sequence: both burst orders
  initial begin
    run(1'b0);
    run(1'b1);
    test_done();
  end

endmodule : tb_pipelined_burst_sram_port
